// [core/uart_shadow_data_port.sv]
// Serial port data path behind sixteen aliased shadow data words
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
module uart_shadow_data_port #(
   parameter int BIT_CYCLES = uart_shadow_pkg::BIT_CYCLES,
   parameter int FIFO_DEPTH = uart_shadow_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Serial and infrared pins
   input wire logic sin_i,
   input wire logic sir_in_i,
   output logic sout_o,
   output logic sir_out_n_o
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;
   localparam int IR_CYC = ((BIT_CYCLES * 3) / 16 > 0) ? (BIT_CYCLES * 3) / 16 : 1;
   localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
   localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);
   localparam logic [15:0] IR_ON = 16'(BIT_CYCLES - IR_CYC);

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic pend_pop;
      logic pend_ovr_clr;
      logic sel_shadow;
      logic fifo_en;
      logic ir_mode;
      logic [7:0] rx_hold;
      logic rx_hold_valid;
      logic overrun;
      logic [7:0] tx_hold;
      logic tx_hold_full;
      uart_shadow_pkg::tx_state_t tx_state;
      logic [15:0] tx_cnt;
      logic [3:0] tx_bits;
      logic [9:0] tx_shift;
      logic sout;
      logic sir_out_n;
      uart_shadow_pkg::rx_state_t rx_state;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bits;
      logic [7:0] rx_shift;
   } port_state_t;

   port_state_t r_reg, r_next;
   logic req, commit, hit, rx_line, rx_present, vacant, tx_idle, tx_bit;
   logic deliver, tx_load, read_pop;
   logic [7:0] rx_head, tx_byte;

   fifo_link_if #(.W(uart_shadow_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) rx_f();
   fifo_link_if #(.W(uart_shadow_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) tx_f();

   shadow_fifo #(.W(uart_shadow_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .port(rx_f.store)
   );

   shadow_fifo #(.W(uart_shadow_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .port(tx_f.store)
   );

   assign req = cyc_i & stb_i & ~r_reg.ack;
   // Effects land on the edge where the master samples ack
   assign commit = cyc_i & stb_i & r_reg.ack;
   assign hit = uart_shadow_pkg::shadow_hit(adr_i);
   assign rx_line = r_reg.ir_mode ? sir_in_i : sin_i;
   assign rx_present = r_reg.fifo_en ? rx_f.out_valid : r_reg.rx_hold_valid;
   assign rx_head = r_reg.fifo_en ? rx_f.out_data : r_reg.rx_hold;
   assign vacant = r_reg.fifo_en ? ~tx_f.out_valid : ~r_reg.tx_hold_full;
   assign tx_idle = (r_reg.tx_state == uart_shadow_pkg::TX_IDLE);
   assign tx_byte = r_reg.fifo_en ? tx_f.out_data : r_reg.tx_hold;
   assign read_pop = commit & ~we_i & r_reg.pend_pop;
   assign dat_o = r_reg.dat;
   assign ack_o = r_reg.ack;
   assign sout_o = r_reg.sout;
   assign sir_out_n_o = r_reg.sir_out_n;

   always_comb begin
      r_next = r_reg;
      deliver = 1'b0;
      tx_load = 1'b0;
      tx_bit = 1'b1;
      rx_f.in_valid = 1'b0;
      rx_f.in_data = r_reg.rx_shift;
      rx_f.out_ready = 1'b0;
      rx_f.flush = 1'b0;
      tx_f.in_valid = 1'b0;
      tx_f.in_data = dat_i[7:0];
      tx_f.out_ready = r_reg.fifo_en & tx_idle;
      tx_f.flush = 1'b0;
      r_next.ack = req;

      // Bus: decode and capture read data at the request
      if (req) begin
         r_next.dat = '0;
         r_next.sel_shadow = hit;
         r_next.pend_pop = 1'b0;
         r_next.pend_ovr_clr = 1'b0;
         if (hit) begin
            r_next.dat = {24'h00_0000, rx_head};
            // Only a byte that is really present is consumed
            r_next.pend_pop = ~we_i & rx_present;
         end else if (adr_i == uart_shadow_pkg::LINE_STATE_ADDR) begin
            r_next.dat[uart_shadow_pkg::RX_PRESENT_BIT] = rx_present;
            r_next.dat[uart_shadow_pkg::OVERRUN_BIT] = r_reg.overrun;
            r_next.dat[uart_shadow_pkg::TX_VACANT_BIT] = vacant;
            r_next.dat[uart_shadow_pkg::TX_IDLE_BIT] = vacant & tx_idle;
            r_next.pend_ovr_clr = ~we_i;
         end else if (adr_i == uart_shadow_pkg::FIFO_SETUP_ADDR) begin
            r_next.dat[uart_shadow_pkg::FIFO_EN_BIT] = r_reg.fifo_en;
         end else if (adr_i == uart_shadow_pkg::MODE_ADDR) begin
            r_next.dat[uart_shadow_pkg::IR_MODE_BIT] = r_reg.ir_mode;
         end
      end

      if (read_pop) begin
         if (r_reg.fifo_en) begin
            rx_f.out_ready = 1'b1;
         end else begin
            r_next.rx_hold_valid = 1'b0;
         end
      end
      if (commit & ~we_i & r_reg.pend_ovr_clr) begin
         r_next.overrun = 1'b0;
      end

      // Transmit shifter
      case (r_reg.tx_state)
         uart_shadow_pkg::TX_IDLE: begin
            if (r_reg.fifo_en ? tx_f.out_valid : r_reg.tx_hold_full) begin
               tx_load = 1'b1;
               r_next.tx_shift = {1'b1, tx_byte, 1'b0};
               r_next.tx_cnt = BIT_LAST;
               r_next.tx_bits = 4'h0;
               r_next.tx_state = uart_shadow_pkg::TX_SHIFT;
               if (!r_reg.fifo_en) begin
                  r_next.tx_hold_full = 1'b0;
               end
            end
         end
         uart_shadow_pkg::TX_SHIFT: begin
            if (r_reg.tx_cnt == 16'h0000) begin
               if (r_reg.tx_bits == 4'h9) begin
                  r_next.tx_state = uart_shadow_pkg::TX_IDLE;
               end else begin
                  r_next.tx_shift = {1'b1, r_reg.tx_shift[9:1]};
                  r_next.tx_bits = r_reg.tx_bits + 4'h1;
                  r_next.tx_cnt = BIT_LAST;
               end
            end else begin
               r_next.tx_cnt = r_reg.tx_cnt - 16'h0001;
            end
         end
         default: begin
            r_next.tx_state = uart_shadow_pkg::TX_IDLE;
         end
      endcase
      if (r_next.tx_state == uart_shadow_pkg::TX_SHIFT) begin
         tx_bit = r_next.tx_shift[0];
      end
      // Infrared sends a low pulse in the first part of each zero bit
      r_next.sout = r_reg.ir_mode ? 1'b1 : tx_bit;
      r_next.sir_out_n = ~(r_reg.ir_mode & ~tx_bit & (r_next.tx_cnt >= IR_ON));

      // Bus writes after the loader, so a write in the load cycle wins
      if (commit & we_i & sel_i[0]) begin
         if (hit) begin
            if (r_reg.fifo_en) begin
               tx_f.in_valid = 1'b1;
            end else begin
               r_next.tx_hold = dat_i[7:0];
               r_next.tx_hold_full = 1'b1;
            end
         end else if (adr_i == uart_shadow_pkg::FIFO_SETUP_ADDR) begin
            r_next.fifo_en = dat_i[uart_shadow_pkg::FIFO_EN_BIT];
            // A mode change empties both paths so no stale byte leaks across
            if (dat_i[uart_shadow_pkg::FIFO_EN_BIT] != r_reg.fifo_en) begin
               rx_f.flush = 1'b1;
               tx_f.flush = 1'b1;
               r_next.rx_hold_valid = 1'b0;
               r_next.tx_hold_full = 1'b0;
            end
            if (dat_i[uart_shadow_pkg::RX_FLUSH_BIT]) begin
               rx_f.flush = 1'b1;
            end
            if (dat_i[uart_shadow_pkg::TX_FLUSH_BIT]) begin
               tx_f.flush = 1'b1;
            end
         end else if (adr_i == uart_shadow_pkg::MODE_ADDR) begin
            r_next.ir_mode = dat_i[uart_shadow_pkg::IR_MODE_BIT];
         end
      end

      // Receive framer, sampling mid-bit
      case (r_reg.rx_state)
         uart_shadow_pkg::RX_IDLE: begin
            if (!rx_line) begin
               r_next.rx_cnt = BIT_HALF;
               r_next.rx_state = uart_shadow_pkg::RX_START;
            end
         end
         uart_shadow_pkg::RX_START: begin
            if (r_reg.rx_cnt == 16'h0000) begin
               r_next.rx_state = rx_line ? uart_shadow_pkg::RX_IDLE : uart_shadow_pkg::RX_DATA;
               r_next.rx_cnt = BIT_LAST;
               r_next.rx_bits = 4'h0;
            end else begin
               r_next.rx_cnt = r_reg.rx_cnt - 16'h0001;
            end
         end
         uart_shadow_pkg::RX_DATA: begin
            if (r_reg.rx_cnt == 16'h0000) begin
               r_next.rx_shift = {rx_line, r_reg.rx_shift[7:1]};
               r_next.rx_cnt = BIT_LAST;
               r_next.rx_bits = r_reg.rx_bits + 4'h1;
               if (r_reg.rx_bits == 4'h7) begin
                  r_next.rx_state = uart_shadow_pkg::RX_STOP;
               end
            end else begin
               r_next.rx_cnt = r_reg.rx_cnt - 16'h0001;
            end
         end
         uart_shadow_pkg::RX_STOP: begin
            if (r_reg.rx_cnt == 16'h0000) begin
               r_next.rx_state = uart_shadow_pkg::RX_IDLE;
               // A bad stop bit drops the byte silently
               deliver = rx_line;
            end else begin
               r_next.rx_cnt = r_reg.rx_cnt - 16'h0001;
            end
         end
         default: begin
            r_next.rx_state = uart_shadow_pkg::RX_IDLE;
         end
      endcase

      // Delivery last: a new byte or overrun beats a read or clear
      if (deliver) begin
         if (r_reg.fifo_en) begin
            rx_f.in_valid = 1'b1;
            if (!rx_f.in_ready) begin
               r_next.overrun = 1'b1;
            end
         end else begin
            if (r_reg.rx_hold_valid & ~read_pop) begin
               r_next.overrun = 1'b1;
            end
            r_next.rx_hold = r_reg.rx_shift;
            r_next.rx_hold_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_reg <= '0;
         r_reg.rx_hold <= uart_shadow_pkg::SHADOW_RESET;
         r_reg.tx_hold <= uart_shadow_pkg::SHADOW_RESET;
         r_reg.tx_state <= uart_shadow_pkg::TX_IDLE;
         r_reg.rx_state <= uart_shadow_pkg::RX_IDLE;
         r_reg.sout <= 1'b1;
         r_reg.sir_out_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      req |=> ack_o ##1 !ack_o)
      else $error("ack not a single cycle after request");
   a_alias_read_byte: assert property (@(posedge clk_i) disable iff (rst_i)
      req & ~we_i & hit & ~r_reg.fifo_en |=> dat_o[7:0] == $past(r_reg.rx_hold))
      else $error("alias read returned wrong byte");
   a_reserved_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o & r_reg.sel_shadow |-> dat_o[31:8] == 24'h00_0000)
      else $error("reserved data bits not zero");
   a_overrun_replace: assert property (@(posedge clk_i) disable iff (rst_i)
      deliver & ~r_reg.fifo_en & r_reg.rx_hold_valid & ~read_pop
      |=> r_reg.overrun & r_reg.rx_hold == $past(r_reg.rx_shift))
      else $error("unread byte not replaced with overrun");
   a_full_rx_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
      deliver & r_reg.fifo_en & ~rx_f.in_ready & ~rx_f.out_ready & ~rx_f.flush
      |=> r_reg.overrun && $stable(rx_f.level))
      else $error("full receive FIFO disturbed or no overrun");
   a_vacant_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      commit & we_i & sel_i[0] & hit & ~r_reg.fifo_en & vacant |=> !vacant)
      else $error("write did not clear holding vacant flag");
   a_hold_replaced: assert property (@(posedge clk_i) disable iff (rst_i)
      commit & we_i & sel_i[0] & hit & ~r_reg.fifo_en & r_reg.tx_hold_full
      |=> r_reg.tx_hold == $past(dat_i[7:0]) && r_reg.tx_hold_full)
      else $error("pending transmit byte not replaced");
   a_tx_fifo_accept: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_f.in_valid & tx_f.in_ready & ~tx_f.out_ready & ~tx_f.flush
      |=> tx_f.level == LW'($past(tx_f.level) + 1))
      else $error("transmit FIFO did not accept write");
   a_tx_fifo_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_f.in_valid & ~tx_f.in_ready & ~(tx_f.out_valid & tx_f.out_ready) & ~tx_f.flush
      |=> $stable(tx_f.level))
      else $error("write to full transmit FIFO disturbed queue");
   a_start_bit_out: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_load & ~r_reg.ir_mode |=> !sout_o ##1 !sout_o)
      else $error("start bit missing on serial output");

   c_rx_fifo_full: cover property (@(posedge clk_i) disable iff (rst_i)
      rx_f.level == LW'(FIFO_DEPTH));
   c_overrun: cover property (@(posedge clk_i) disable iff (rst_i) r_reg.overrun);
   c_ir_pulse: cover property (@(posedge clk_i) disable iff (rst_i) !sir_out_n_o);
   c_alias_15: cover property (@(posedge clk_i) disable iff (rst_i)
      req & adr_i == uart_shadow_pkg::SHADOW_ALIAS_15);
endmodule

// [core/uart_shadow_pkg.sv]
// Constants, addresses and state encodings for the shadow data port
package uart_shadow_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int BAUD_RATE = 115_200;
   localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
   localparam int FIFO_DEPTH = 16;
   localparam int DATA_W = 8;
   // Sixteen aliases, one word each, ending at alias 15
   localparam logic [31:0] SHADOW_ALIAS_0 = 32'h5000_1030;
   localparam logic [31:0] SHADOW_ALIAS_14 = 32'h5000_1068;
   localparam logic [31:0] SHADOW_ALIAS_15 = 32'h5000_106C;
   localparam logic [29:0] SHADOW_ALIAS_COUNT = 30'h0000_0010;
   localparam logic [31:0] FIFO_SETUP_ADDR = 32'h5000_1008;
   localparam logic [31:0] LINE_STATE_ADDR = 32'h5000_1014;
   localparam logic [31:0] MODE_ADDR = 32'h5000_1024;
   // fifo_setup_reg fields
   localparam int FIFO_EN_BIT = 0;
   localparam int RX_FLUSH_BIT = 1;
   localparam int TX_FLUSH_BIT = 2;
   // Mode register field
   localparam int IR_MODE_BIT = 0;
   // line_state_reg fields
   localparam int RX_PRESENT_BIT = 0;
   localparam int OVERRUN_BIT = 1;
   localparam int TX_VACANT_BIT = 5;
   localparam int TX_IDLE_BIT = 6;
   localparam logic [7:0] SHADOW_RESET = 8'h00;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SHIFT = 2'b10
   } tx_state_t;

   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } rx_state_t;

   function automatic logic shadow_hit(input logic [31:0] adr);
      logic [29:0] d;
      d = adr[31:2] - SHADOW_ALIAS_0[31:2];
      return d < SHADOW_ALIAS_COUNT;
   endfunction
endpackage

// [core/fifo_link_if.sv]
// Valid/ready link between the port logic and a byte FIFO
`timescale 1ns/1ps
interface fifo_link_if #(parameter int W = 8, parameter int DEPTH = 16);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   logic flush;
   logic [$clog2(DEPTH):0] level;
   modport store(input in_valid, in_data, out_ready, flush,
                 output in_ready, out_valid, out_data, level);
   modport user(output in_valid, in_data, out_ready, flush,
                input in_ready, out_valid, out_data, level);
endinterface

// [core/shadow_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module shadow_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Link
   fifo_link_if.store port
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [AW:0] cnt;
   } fifo_state_t;

   fifo_state_t r_reg, r_next;
   logic push, pop;

   function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   // Full stops intake outright, so a full queue is never disturbed
   assign port.in_ready = (r_reg.cnt != FULL);
   assign port.out_valid = (r_reg.cnt != '0);
   assign port.out_data = r_reg.mem[r_reg.rd];
   assign port.level = r_reg.cnt;
   assign push = port.in_valid & port.in_ready;
   assign pop = port.out_valid & port.out_ready;

   always_comb begin
      r_next = r_reg;
      if (port.flush) begin
         r_next.rd = '0;
         r_next.wr = '0;
         r_next.cnt = '0;
      end else begin
         if (push) begin
            r_next.mem[r_reg.wr] = port.in_data;
            r_next.wr = step(r_reg.wr);
         end
         if (pop) begin
            r_next.rd = step(r_reg.rd);
         end
         r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule

// [bench/serial_peer.sv]
// Remote serial and infrared peer for the shadow data port
`timescale 1ns/1ps
module serial_peer #(
   parameter int BC = 8
) (
   // Clock, reset and mode
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ir_i,
   // Lines from the port
   input wire logic sout_i,
   input wire logic sir_out_n_i,
   // Lines to the port
   output logic sin_o,
   output logic sir_in_o
);
   logic line_drv = 1'b1;
   logic [7:0] rx_q[$];
   logic line;
   logic low;
   logic [7:0] b;
   // Unused input idles high, as its pull-up would leave it
   assign sin_o = ir_i ? 1'b1 : line_drv;
   assign sir_in_o = ir_i ? line_drv : 1'b1;
   assign line = ir_i ? sir_out_n_i : sout_i;

   // 8N1, LSB first, line left high after the stop bit
   task automatic send_byte(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_i);
         line_drv <= f[i];
         repeat (BC - 1) @(posedge clk_i);
      end
   endtask

   // Infrared zeros are short pulses, so any low in the window counts
   initial begin
      forever begin
         @(posedge clk_i);
         if (!rst_i && line === 1'b0) begin
            repeat (BC / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
               low = 1'b0;
               for (int c = 0; c < BC; c++) begin
                  @(posedge clk_i);
                  if (line === 1'b0) low = 1'b1;
                  if (!ir_i && c == BC - 1) b[i] = line;
               end
               if (ir_i) b[i] = !low;
            end
            rx_q.push_back(b);
            repeat (BC) @(posedge clk_i);
         end
      end
   end
endmodule

// [bench/uart_shadow_data_port_test.sv]
// Self-checking bench for the shadow data port
`timescale 1ns/1ps
module uart_shadow_data_port_test;
   // Short bit time keeps the FIFO scenarios quick
   localparam int BC = 8;
   localparam logic [31:0] LS_ADDR = uart_shadow_pkg::LINE_STATE_ADDR;
   localparam logic [31:0] A0 = uart_shadow_pkg::SHADOW_ALIAS_0;
   localparam logic [31:0] A14 = uart_shadow_pkg::SHADOW_ALIAS_14;
   localparam logic [31:0] A15 = uart_shadow_pkg::SHADOW_ALIAS_15;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [31:0] adr_i = 32'h0;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic sin_i;
   logic sir_in_i;
   logic sout_o;
   logic sir_out_n_o;
   logic ir = 1'b0;
   logic [31:0] q;
   int fail_count = 0;
   int checked = 0;

   always #10 clk_i = ~clk_i;

   uart_shadow_data_port #(.BIT_CYCLES(BC), .FIFO_DEPTH(16)) uart_shadow_data_port_i (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .sin_i(sin_i), .sir_in_i(sir_in_i), .sout_o(sout_o), .sir_out_n_o(sir_out_n_o));

   serial_peer #(.BC(BC)) serial_peer_i (
      .clk_i(clk_i), .rst_i(rst_i), .ir_i(ir), .sout_i(sout_o),
      .sir_out_n_i(sir_out_n_o), .sin_o(sin_i), .sir_in_o(sir_in_i));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Classic cycle; never assumes the answer latency
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (ack_o !== 1'b1) chk({31'h0, ack_o}, 32'h1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask

   task automatic expect_tx(input logic [7:0] e);
      int n;
      n = 0;
      while (serial_peer_i.rx_q.size() == 0 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      if (serial_peer_i.rx_q.size() == 0) chk(32'h0000_0100, {24'h0, e});
      else chk({24'h0, serial_peer_i.rx_q.pop_front()}, {24'h0, e});
   endtask

   task automatic t_reset;
      rd(LS_ADDR, 32'h0000_0063, 32'h0000_0060);
      rd(A14, ALL, 32'h0);
      rd(32'h5000_1100, ALL, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_tx_plain;
      rd(LS_ADDR, 32'h0000_0020, 32'h0000_0020);
      wb(1'b1, A14, 32'hFFFF_FFA5);
      wb(1'b1, A0 + 32'h4, 32'h0000_005A);
      wb(1'b1, A15, 32'h0000_00C3);
      rd(LS_ADDR, 32'h0000_0020, 32'h0);
      expect_tx(8'hA5);
      expect_tx(8'hC3);
      $display("test tx_plain done");
   endtask

   task automatic t_rx_plain;
      serial_peer_i.send_byte(8'h3C);
      rd(LS_ADDR, 32'h1, 32'h1);
      rd(A15, ALL, 32'h3C);
      rd(LS_ADDR, 32'h1, 32'h0);
      serial_peer_i.send_byte(8'h11);
      serial_peer_i.send_byte(8'h22);
      rd(LS_ADDR, 32'h3, 32'h3);
      rd(A0, ALL, 32'h22);
      $display("test rx_plain done");
   endtask

   // Writes outpace the shifter, so one lands in it and the 18th finds the FIFO full
   task automatic t_fifo;
      wb(1'b1, uart_shadow_pkg::FIFO_SETUP_ADDR, 32'h1);
      for (int i = 0; i < 17; i++) serial_peer_i.send_byte(8'(8'h40 + i));
      rd(LS_ADDR, 32'h3, 32'h3);
      for (int i = 0; i < 16; i++) rd(A0 + 32'(i * 4), ALL, 32'(8'h40 + i));
      rd(LS_ADDR, 32'h1, 32'h0);
      for (int i = 0; i < 18; i++) wb(1'b1, A0 + 32'((i % 16) * 4), 32'hFFFF_FF80 + i);
      for (int i = 0; i < 17; i++) expect_tx(8'(8'h80 + i));
      repeat (12 * BC) @(posedge clk_i);
      chk(32'(serial_peer_i.rx_q.size()), 32'h0);
      // Receive flush keeps FIFO mode but empties the queue
      rd(uart_shadow_pkg::FIFO_SETUP_ADDR, 32'h1, 32'h1);
      serial_peer_i.send_byte(8'h5D);
      rd(LS_ADDR, 32'h1, 32'h1);
      wb(1'b1, uart_shadow_pkg::FIFO_SETUP_ADDR, 32'h3);
      rd(LS_ADDR, 32'h1, 32'h0);
      $display("test fifo done");
   endtask

   task automatic t_ir;
      wb(1'b1, uart_shadow_pkg::FIFO_SETUP_ADDR, 32'h0);
      wb(1'b1, uart_shadow_pkg::MODE_ADDR, 32'h1);
      ir <= 1'b1;
      serial_peer_i.send_byte(8'h96);
      rd(A14, ALL, 32'h96);
      wb(1'b1, A0, 32'h0000_005B);
      expect_tx(8'h5B);
      chk({31'h0, sout_o}, 32'h1);
      rd(uart_shadow_pkg::MODE_ADDR, 32'h1, 32'h1);
      // Upper lanes only: nothing may be queued or sent
      sel_i <= 4'hE;
      wb(1'b1, A15, 32'h0000_0077);
      sel_i <= 4'hF;
      repeat (12 * BC) @(posedge clk_i);
      rd(LS_ADDR, 32'h0000_0060, 32'h0000_0060);
      chk(32'(serial_peer_i.rx_q.size()), 32'h0);
      $display("test ir done");
   endtask

   task automatic results;
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_tx_plain;
      t_rx_plain;
      t_fifo;
      t_ir;
      results;
   end

   // Tests need about 4000 cycles; this leaves ample margin
   initial begin
      repeat (40000) @(posedge clk_i);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      results;
   end
endmodule
